// File: bmc2_regs.sv
// Purpose: second misc control register and the control it applies
// Assumes: sys_rst synchronous active high; straps and the interrupt
//          line are pins, all other inputs are core_clk logic
// Notes:   register port reads answer one cycle after the strobe
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "bmc2_map.svh"

module bmc2_regs #(
  parameter int unsigned LRST_CYC = `BMC2_LRST_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // register port
  input  wire logic [11:0]                reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  output logic                            irq,
  // straps and pins
  input  wire logic                       pci_disable_strap,
  input  wire logic                       sda_pin,
  input  wire logic                       eeprom_present_strap,
  input  wire logic                       local_interrupt_line_n,
  // eeprom loader
  input  wire logic                       ee_load,
  input  wire logic                       ee_pci_access_disable,
  // termination mapping
  input  wire logic                       master_abort_error_disable,
  input  wire bmc2_pkg::bmc2_pci_done_type pci_done,
  output bmc2_pkg::bmc2_term_type          local_term,
  // burst and prefetch shape
  input  wire logic [2:0]                 wr_burst_req,
  output logic      [2:0]                 wr_burst_phases,
  output logic                            prefetch_single,
  input  wire logic                       pf_image,
  input  wire logic [5:0]                 first_prefetch_count,
  output logic      [7:0]                 prefetch_bytes,
  // channel policy
  output logic                            slave_channel_posted_write,
  output logic                            ordering_enforce,
  // register port arbitration
  input  wire logic                       reg_req_pci,
  input  wire logic                       reg_req_local,
  output logic                            reg_port_local,
  // local-bus parity
  input  wire bmc2_pkg::bmc2_par_word_type par_check,
  input  wire logic [31:0]                par_gen_data,
  output logic                            par_gen_bit,
  output logic                            par_error,
  // eeprom, power and pci access
  output logic                            eeprom_access_allowed,
  input  wire logic [1:0]                 pm_state,
  input  wire logic                       pme_enable,
  output logic                            pme_assert,
  output logic                            internal_reset_req,
  output logic                            local_reset_output_n,
  output logic                            pci_retry_all
);

  // control fields
  logic       pci_access_disable_q;
  logic       image_based_prefetch_q;
  logic       abort_to_error_enable_q;
  logic       full_burst_q;
  logic       single_prefetch_q;
  logic       scpw_q;
  logic [5:0] second_prefetch_count_q;
  logic       register_port_parking_q;
  logic       local_parity_sense_q;
  logic       late_eeprom_access_enable_q;
  logic       no_ordering_q;
  logic       power_state_reset_q;
  logic       wake_support_q;

  logic [`BMC2_EV_N-1:0] irq_stat_q;
  logic [`BMC2_EV_N-1:0] irq_mask_q;
  logic [`BMC2_EV_N-1:0] ev;
  logic [31:0]           ctl2_rd;
  logic [31:0]           rdata_d;

  logic wr_ctl2;
  logic wr_stat;
  logic wr_mask;

  // pin synchronisers, free running so straps settle during reset
  logic [1:0] dis_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] present_sync_q;
  logic [1:0] int_sync_q;
  logic       strap_take_q;
  logic       eeprom_present_q;

  logic [1:0]  pm_prev_q;
  logic [31:0] lrst_cnt_q;
  logic        lrst_active_q;
  logic        ps_reset_ev;
  logic        wake_d;
  logic        wake_q;

  assign wr_ctl2 = reg_wr && (reg_addr == `BMC2_OFF_CTL2);
  assign wr_stat = reg_wr && (reg_addr == `BMC2_OFF_STAT);
  assign wr_mask = reg_wr && (reg_addr == `BMC2_OFF_MASK);

  // two flops on every pin before any logic looks at it
  always_ff @(posedge core_clk) begin
    dis_sync_q     <= {dis_sync_q[0], pci_disable_strap};
    sda_sync_q     <= {sda_sync_q[0], sda_pin};
    present_sync_q <= {present_sync_q[0], eeprom_present_strap};
    int_sync_q     <= {int_sync_q[0], local_interrupt_line_n};
  end

  // straps are caught on the first edge after reset release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strap_take_q <= 1'b1;
    end else begin
      strap_take_q <= 1'b0;
    end
  end

  // eeprom seen at power-up if either strap line was high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eeprom_present_q <= 1'b0;
    end else if (strap_take_q) begin
      eeprom_present_q <= sda_sync_q[1] | present_sync_q[1];
    end
  end

  // pci access disable: strap, then eeprom, then local software
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pci_access_disable_q <= 1'b0;
    end else if (strap_take_q) begin
      pci_access_disable_q <= dis_sync_q[1];
    end else if (ee_load) begin
      pci_access_disable_q <= ee_pci_access_disable;
    end else if (wr_ctl2) begin
      pci_access_disable_q <= reg_wdata[`BMC2_B_PCIDIS];
    end
  end

  // software fields of the control register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      image_based_prefetch_q      <= 1'b0;
      abort_to_error_enable_q     <= 1'b0;
      full_burst_q                <= 1'b0;
      single_prefetch_q           <= 1'b0;
      scpw_q                      <= 1'b0;
      second_prefetch_count_q     <= `BMC2_CNT2_RST;
      register_port_parking_q     <= 1'b0;
      local_parity_sense_q        <= 1'b0;
      late_eeprom_access_enable_q <= 1'b0;
      no_ordering_q               <= 1'b0;
      power_state_reset_q         <= 1'b0;
      wake_support_q              <= 1'b0;
    end else if (wr_ctl2) begin
      image_based_prefetch_q      <= reg_wdata[`BMC2_B_IMGPF];
      abort_to_error_enable_q     <= reg_wdata[`BMC2_B_TAERR];
      full_burst_q                <= reg_wdata[`BMC2_B_FULLB];
      single_prefetch_q           <= reg_wdata[`BMC2_B_SINGPF];
      scpw_q                      <= reg_wdata[`BMC2_B_SCPW];
      second_prefetch_count_q     <= reg_wdata[`BMC2_B_CNT2_HI:`BMC2_B_CNT2_LO];
      register_port_parking_q     <= reg_wdata[`BMC2_B_PARK];
      local_parity_sense_q        <= reg_wdata[`BMC2_B_PARSENS];
      late_eeprom_access_enable_q <= reg_wdata[`BMC2_B_LATEEE];
      no_ordering_q               <= reg_wdata[`BMC2_B_NOORD];
      power_state_reset_q         <= reg_wdata[`BMC2_B_PSRST];
      wake_support_q              <= reg_wdata[`BMC2_B_WAKE];
    end
  end

  // termination mapping of delayed local cycles
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      local_term <= '0;
    end else begin
      local_term.valid <= pci_done.valid;
      local_term.bus_error <= pci_done.valid && pci_done.delayed &&
        ((pci_done.target_abort &&
          (abort_to_error_enable_q || !master_abort_error_disable)) ||
         (pci_done.master_abort && !master_abort_error_disable));
    end
  end

  // burst shape: short bursts split into singles in full-burst mode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_burst_phases <= `BMC2_BURST_ONE;
    end else if (full_burst_q && (wr_burst_req != `BMC2_BURST_FULL)) begin
      wr_burst_phases <= `BMC2_BURST_ONE;
    end else begin
      wr_burst_phases <= wr_burst_req;
    end
  end

  // prefetch amount in bytes, four per count unit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prefetch_bytes <= '0;
    end else if (image_based_prefetch_q && pf_image) begin
      prefetch_bytes <= {second_prefetch_count_q, 2'h0};
    end else begin
      prefetch_bytes <= {first_prefetch_count, 2'h0};
    end
  end

  // plain policy levels, registered so they change one edge after a write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prefetch_single            <= 1'b0;
      slave_channel_posted_write <= 1'b0;
      ordering_enforce           <= 1'b1;
      eeprom_access_allowed      <= 1'b0;
      pci_retry_all              <= 1'b0;
    end else begin
      prefetch_single            <= single_prefetch_q;
      slave_channel_posted_write <= scpw_q;
      ordering_enforce           <= !no_ordering_q;
      eeprom_access_allowed      <= eeprom_present_q || late_eeprom_access_enable_q;
      pci_retry_all              <= pci_access_disable_q;
    end
  end

  // register port owner; pci wins a tie because it cannot be stalled
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_port_local <= 1'b0;
    end else if (reg_req_pci) begin
      reg_port_local <= 1'b0;
    end else if (reg_req_local) begin
      reg_port_local <= 1'b1;
    end else if (!register_port_parking_q) begin
      reg_port_local <= 1'b0;
    end
  end

  // parity generation and check
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      par_gen_bit <= 1'b0;
      par_error   <= 1'b0;
    end else begin
      par_gen_bit <= (^par_gen_data) ^ local_parity_sense_q;
      par_error   <= par_check.valid &&
        (((^par_check.data) ^ par_check.parity) != local_parity_sense_q);
    end
  end

  // power-state change watch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pm_prev_q <= `BMC2_D0;
    end else begin
      pm_prev_q <= pm_state;
    end
  end

  assign ps_reset_ev = power_state_reset_q && (pm_prev_q == `BMC2_D3HOT) &&
                       (pm_state == `BMC2_D0);

  // local reset pulse; a new change restarts the full width
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lrst_cnt_q    <= '0;
      lrst_active_q <= 1'b0;
    end else if (ps_reset_ev) begin
      lrst_cnt_q    <= LRST_CYC - 1;
      lrst_active_q <= 1'b1;
    end else if (lrst_cnt_q != '0) begin
      lrst_cnt_q    <= lrst_cnt_q - 32'h1;
    end else begin
      lrst_active_q <= 1'b0;
    end
  end

  assign internal_reset_req   = lrst_active_q;
  assign local_reset_output_n = !lrst_active_q;

  assign wake_d = wake_support_q && pme_enable &&
                  (pm_state == `BMC2_D3HOT) && !int_sync_q[1];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign pme_assert = wake_q;

  // interrupt events, one-cycle pulses
  always_comb begin
    ev                  = '0;
    ev[`BMC2_EV_BUSERR] = local_term.bus_error;
    ev[`BMC2_EV_PARERR] = par_error;
    ev[`BMC2_EV_PSRST]  = ps_reset_ev;
    ev[`BMC2_EV_WAKE]   = wake_d && !wake_q;
  end

  // sticky status: a new event beats a write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_stat_q <= `BMC2_IRQ_RST;
    end else if (wr_stat) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata[`BMC2_EV_N-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_mask_q <= `BMC2_IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata[`BMC2_EV_N-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read image of the control register, unused bits zero
  always_comb begin
    ctl2_rd                                  = '0;
    ctl2_rd[`BMC2_B_PCIDIS]                  = pci_access_disable_q;
    ctl2_rd[`BMC2_B_IMGPF]                   = image_based_prefetch_q;
    ctl2_rd[`BMC2_B_TAERR]                   = abort_to_error_enable_q;
    ctl2_rd[`BMC2_B_FULLB]                   = full_burst_q;
    ctl2_rd[`BMC2_B_SINGPF]                  = single_prefetch_q;
    ctl2_rd[`BMC2_B_SCPW]                    = scpw_q;
    ctl2_rd[`BMC2_B_CNT2_HI:`BMC2_B_CNT2_LO] = second_prefetch_count_q;
    ctl2_rd[`BMC2_B_PARK]                    = register_port_parking_q;
    ctl2_rd[`BMC2_B_PARSENS]                 = local_parity_sense_q;
    ctl2_rd[`BMC2_B_LATEEE]                  = late_eeprom_access_enable_q;
    ctl2_rd[`BMC2_B_NOORD]                   = no_ordering_q;
    ctl2_rd[`BMC2_B_PSRST]                   = power_state_reset_q;
    ctl2_rd[`BMC2_B_WAKE]                    = wake_support_q;
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `BMC2_OFF_CTL2: rdata_d = ctl2_rd;
        `BMC2_OFF_STAT: rdata_d[`BMC2_EV_N-1:0] = irq_stat_q;
        `BMC2_OFF_MASK: rdata_d[`BMC2_EV_N-1:0] = irq_mask_q;
        default:        rdata_d = '0;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// File: bmc2_map.svh
// Purpose: offsets, field positions, reset values and timing for the
//          second misc control register bank
// Assumes: 32-bit register port, byte addresses
// Notes:   definitions only
`ifndef BMC2_MAP_SVH
`define BMC2_MAP_SVH

// register byte addresses
`define BMC2_OFF_CTL2     12'h808
`define BMC2_OFF_STAT     12'h820
`define BMC2_OFF_MASK     12'h824

// field positions in misc_control_two
`define BMC2_B_PCIDIS     31
`define BMC2_B_IMGPF      23
`define BMC2_B_TAERR      18
`define BMC2_B_FULLB      17
`define BMC2_B_SINGPF     16
`define BMC2_B_SCPW       15
`define BMC2_B_CNT2_HI    14
`define BMC2_B_CNT2_LO    9
`define BMC2_B_PARK       8
`define BMC2_B_PARSENS    4
`define BMC2_B_LATEEE     3
`define BMC2_B_NOORD      2
`define BMC2_B_PSRST      1
`define BMC2_B_WAKE       0

// reset values
`define BMC2_CNT2_RST     6'h01
`define BMC2_IRQ_RST      4'h0

// interrupt event bits
`define BMC2_EV_BUSERR    0
`define BMC2_EV_PARERR    1
`define BMC2_EV_PSRST     2
`define BMC2_EV_WAKE      3
`define BMC2_EV_N         4

// power states and burst sizes
`define BMC2_D0           2'h0
`define BMC2_D3HOT        2'h3
`define BMC2_BURST_FULL   3'h4
`define BMC2_BURST_ONE    3'h1

// local reset pulse width after a power-state reset
`define BMC2_CLK_NS       10
`define BMC2_LRST_NS      1000
`define BMC2_LRST_CYC     ((`BMC2_LRST_NS + `BMC2_CLK_NS - 1) / `BMC2_CLK_NS)

`endif

// File: bmc2_pkg.sv
// Purpose: shared types of the second misc control register bank
// Assumes: 32-bit local-bus data word; no map header is included
// Notes:   types only
package bmc2_pkg;

  // one finished pci transaction behind a local-bus cycle
  typedef struct packed {
    logic valid;
    logic delayed;
    logic target_abort;
    logic master_abort;
  } bmc2_pci_done_type;

  // answer to the local-bus cycle
  typedef struct packed {
    logic valid;
    logic bus_error;
  } bmc2_term_type;

  // local-bus data word with its parity
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        parity;
  } bmc2_par_word_type;

endpackage

// File: bmc2_regs_checker.sv
// Purpose: port-level checks of the second misc control register bank
// Assumes: bound into bmc2_regs; a shadow of the control word follows writes
// Notes:   bit 31 is not checked from the shadow, the strap and the loader also move it
`timescale 1ns/1ns
`include "bmc2_map.svh"

module bmc2_regs_checker #(
  parameter int unsigned LRST_CYC = `BMC2_LRST_CYC
) (
  input wire logic                        core_clk,
  input wire logic                        sys_rst,
  input wire logic [11:0]                 reg_addr,
  input wire logic [31:0]                 reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [31:0]                 reg_rdata,
  input wire logic                        ee_load,
  input wire logic                        master_abort_error_disable,
  input wire bmc2_pkg::bmc2_pci_done_type pci_done,
  input wire bmc2_pkg::bmc2_term_type     local_term,
  input wire logic [2:0]                  wr_burst_req,
  input wire logic [2:0]                  wr_burst_phases,
  input wire logic                        prefetch_single,
  input wire logic                        pf_image,
  input wire logic [5:0]                  first_prefetch_count,
  input wire logic [7:0]                  prefetch_bytes,
  input wire logic                        slave_channel_posted_write,
  input wire logic                        ordering_enforce,
  input wire logic [31:0]                 par_gen_data,
  input wire logic                        par_gen_bit,
  input wire logic                        pci_retry_all,
  input wire logic                        internal_reset_req,
  input wire logic                        local_reset_output_n
);
  logic [31:0] ctl_q;
  logic        live_q;
  logic [15:0] low_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // shadow word; live_q keeps reset-time samples out of one-cycle checks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_q  <= 32'h0000_0200;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      if (reg_wr && reg_addr == `BMC2_OFF_CTL2) begin
        ctl_q <= reg_wdata;
      end
    end
  end

  // length of the local reset pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst || local_reset_output_n) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end

  AST_TERM: assert property (pci_done.valid |=> local_term.valid && local_term.bus_error ==
    $past(pci_done.delayed && (pci_done.target_abort && (ctl_q[18] || !master_abort_error_disable)
    || pci_done.master_abort && !master_abort_error_disable))) else $error("termination mapping wrong");
  AST_BURST: assert property (live_q |-> wr_burst_phases ==
    $past(ctl_q[17] ? (wr_burst_req == 3'h4 ? 3'h4 : 3'h1) : wr_burst_req)) else $error("burst shape wrong");
  AST_SINGLE: assert property (live_q |-> prefetch_single == $past(ctl_q[16]))
    else $error("prefetch cycle kind wrong");
  AST_PF_BYTES: assert property (live_q |-> prefetch_bytes ==
    $past(ctl_q[23] && pf_image ? {ctl_q[14:9], 2'b00} : {first_prefetch_count, 2'b00}))
    else $error("prefetch bytes wrong");
  AST_PARITY: assert property (live_q |-> par_gen_bit == $past(^par_gen_data ^ ctl_q[4]))
    else $error("parity sense wrong");
  AST_CHAN: assert property (live_q |-> slave_channel_posted_write == $past(ctl_q[15])
    && ordering_enforce == !$past(ctl_q[2])) else $error("channel policy wrong");
  AST_RETRY: assert property (live_q && !ee_load && reg_wr && reg_addr == `BMC2_OFF_CTL2
    |-> ##2 pci_retry_all == $past(reg_wdata[31], 2)) else $error("access disable wrong");
  AST_LRST: assert property ($rose(local_reset_output_n) |-> low_q == 16'(LRST_CYC))
    else $error("local reset pulse length wrong");
  AST_RST_PAIR: assert property (internal_reset_req == !local_reset_output_n)
    else $error("reset outputs disagree");
  AST_RD_CTL: assert property (live_q && $past(reg_rd && reg_addr == `BMC2_OFF_CTL2) |->
    reg_rdata[30:0] == $past(ctl_q[30:0] & 31'h0087_ff1f)) else $error("control read wrong");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule

// File: bmc2_pci_far.sv
// Purpose: pci side that finishes transactions behind local cycles
// Assumes: the bench asks for one completion at a time
// Notes:   aborts come only when the bench asks for them
`timescale 1ns/1ns

module bmc2_pci_far (
  input  wire logic                   core_clk,
  input  wire logic                   fire,
  input  wire logic                   delayed,
  input  wire logic                   target_abort,
  input  wire logic                   master_abort,
  output bmc2_pkg::bmc2_pci_done_type pci_done
);
  // one-cycle completion, qualifiers drop with valid so nothing stale stands
  always_ff @(posedge core_clk) begin
    pci_done.valid        <= fire;
    pci_done.delayed      <= fire & delayed;
    pci_done.target_abort <= fire & target_abort;
    pci_done.master_abort <= fire & master_abort;
  end
endmodule

// File: tb_top.sv
// Purpose: self-checking bench of the second misc control register bank
// Assumes: core_clk 100 MHz; local reset pulse shortened to LRST cycles
// Notes:   one-cycle relations are also watched by the bound checker
`timescale 1ns/1ns
`include "bmc2_map.svh"

module tb_top;
  localparam int unsigned LRST = 4;
  logic        core_clk = 1'b0;
  logic        sys_rst, reg_wr, reg_rd, pci_disable_strap, sda_pin, eeprom_present_strap;
  logic        local_interrupt_line_n, ee_load, ee_pci_access_disable, master_abort_error_disable;
  logic        pf_image, reg_req_pci, reg_req_local, pme_enable, fire, dly, ta, ma, irq, pci_retry_all;
  logic        prefetch_single, slave_channel_posted_write, ordering_enforce, reg_port_local, local_reset_output_n;
  logic        par_gen_bit, par_error, eeprom_access_allowed, pme_assert, internal_reset_req;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, par_gen_data;
  logic [2:0]  wr_burst_req, wr_burst_phases;
  logic [5:0]  first_prefetch_count;
  logic [7:0]  prefetch_bytes;
  logic [1:0]  pm_state;
  int          miscompares, comparisons;
  bmc2_pkg::bmc2_pci_done_type pci_done;
  bmc2_pkg::bmc2_term_type     local_term;
  bmc2_pkg::bmc2_par_word_type par_check;

  // free-running core clock
  always #5 core_clk = ~core_clk;

  bmc2_regs #(.LRST_CYC(LRST)) dut_u (.*);
  bmc2_pci_far far_u (
    .core_clk     (core_clk),
    .fire         (fire),
    .delayed      (dly),
    .target_abort (ta),
    .master_abort (ma),
    .pci_done     (pci_done)
  );

  // compare, count, report at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // let n edges pass, then sample where outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // reset held four cycles; the strap pin is steady across release
  task automatic s_reset(input logic strap);
    @(posedge core_clk);
    sys_rst           <= 1'b1;
    {pci_disable_strap, sda_pin} <= {strap, strap};
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(3);
    rd(`BMC2_OFF_CTL2, {strap, 31'h0000_0200});
    chk(pci_retry_all, strap);
    rd(`BMC2_OFF_STAT, 32'h0000_0000);
    rd(12'h000, 32'h0000_0000);
    chk({ordering_enforce, eeprom_access_allowed}, {1'b1, strap});
  endtask

  // every field set, an unmapped write between, then all cleared
  task automatic s_regs();
    wr(`BMC2_OFF_CTL2, 32'hffff_ffff);
    wr(12'h004, 32'h0000_0000);
    rd(`BMC2_OFF_CTL2, 32'h8087_ff1f);
    chk({slave_channel_posted_write, ordering_enforce,
      eeprom_access_allowed, pci_retry_all}, 4'hb);
    wr(`BMC2_OFF_CTL2, 32'h0000_0000);
    tick(2);
    chk({slave_channel_posted_write, ordering_enforce,
      eeprom_access_allowed, pci_retry_all}, 4'h4);
  endtask

  // all abort kinds against both control bits, delayed or not
  task automatic s_abort();
    logic exp;
    for (int i = 0; i < 16; i++) begin
      wr(`BMC2_OFF_CTL2, {13'h0000, i[0], 18'h00000});
      @(posedge core_clk);
      master_abort_error_disable <= i[1];
      fire                       <= 1'b1;
      ta                         <= i[2];
      ma                         <= ~i[2];
      dly                        <= i[3];
      @(posedge core_clk);
      fire <= 1'b0;
      @(posedge core_clk);
      exp = i[3] & (i[2] & (i[0] | ~i[1]) | ~i[2] & ~i[1]);
      #1 chk({local_term.valid, local_term.bus_error}, {1'b1, exp});
    end
  endtask

  // bus error left pending: masked, unmasked, then cleared by a one
  task automatic s_irq();
    rd(`BMC2_OFF_STAT, 32'h0000_0001);
    chk(irq, 1'b0);
    wr(`BMC2_OFF_MASK, 32'h0000_000f);
    rd(`BMC2_OFF_MASK, 32'h0000_000f);
    chk(irq, 1'b1);
    wr(`BMC2_OFF_STAT, 32'h0000_0001);
    rd(`BMC2_OFF_STAT, 32'h0000_0000);
    chk(irq, 1'b0);
  endtask

  // burst size, prefetch kind and prefetch byte count per image
  task automatic s_shape();
    logic [2:0] r;
    for (int i = 0; i < 8; i++) begin
      wr(`BMC2_OFF_CTL2, {8'h00, i[0], 5'h00, i[1], i[2], 1'b0, 6'h0c, 9'h000});
      r = i[0] ? 3'h4 : {2'b01, i[2]};
      @(posedge core_clk);
      wr_burst_req         <= r;
      pf_image             <= i[1];
      first_prefetch_count <= 6'h05;
      tick(2);
      chk(wr_burst_phases, (i[1] && r != 3'h4) ? 3'h1 : r);
      chk(prefetch_single, i[2]);
      chk(prefetch_bytes, (i[0] && i[1]) ? 8'h30 : 8'h14);
    end
  endtask

  // generated and checked parity under both senses
  task automatic s_par();
    for (int i = 0; i < 4; i++) begin
      wr(`BMC2_OFF_CTL2, {27'h0000000, i[0], 4'h0});
      @(posedge core_clk);
      par_gen_data <= i[1] ? 32'h0000_0003 : 32'h0000_0007;
      par_check    <= '{valid: 1'b1, data: 32'h0000_0001, parity: i[1]};
      @(posedge core_clk);
      par_check.valid <= 1'b0;
      #1 chk({par_gen_bit, par_error}, {~i[1] ^ i[0], i[1] == i[0]});
    end
    rd(`BMC2_OFF_STAT, 32'h0000_0002);
    wr(`BMC2_OFF_STAT, 32'h0000_000f);
  endtask

  // local user takes the port; parked or back to pci, pci request wins
  task automatic s_park();
    for (int i = 0; i < 2; i++) begin
      wr(`BMC2_OFF_CTL2, {23'h000000, i[0], 8'h00});
      @(posedge core_clk);
      reg_req_local <= 1'b1;
      @(posedge core_clk);
      reg_req_local <= 1'b0;
      tick(2);
      chk(reg_port_local, i[0]);
    end
    @(posedge core_clk);
    {reg_req_pci, reg_req_local} <= 2'b11;
    tick(2);
    chk(reg_port_local, 1'b0);
    @(posedge core_clk);
    {reg_req_pci, reg_req_local} <= 2'b00;
  endtask

  // loader sets the disable bit against a same-cycle write; software clears
  task automatic s_ee();
    @(posedge core_clk);
    {ee_load, ee_pci_access_disable, reg_wr} <= 3'b111;
    reg_addr  <= `BMC2_OFF_CTL2;
    reg_wdata <= 32'h0000_0000;
    @(posedge core_clk);
    {ee_load, reg_wr} <= 2'b00;
    tick(1);
    chk(pci_retry_all, 1'b1);
    wr(`BMC2_OFF_CTL2, 32'h0000_0000);
    tick(2);
    chk(pci_retry_all, 1'b0);
  endtask

  // interrupt pin in D3hot, then back to D0 with power reset off
  task automatic s_pme(input logic en);
    wr(`BMC2_OFF_CTL2, {31'h00000000, en});
    @(posedge core_clk);
    {pme_enable, local_interrupt_line_n} <= 2'b10;
    pm_state <= `BMC2_D3HOT;
    tick(5);
    chk(pme_assert, en);
    @(posedge core_clk);
    local_interrupt_line_n <= 1'b1;
    pm_state               <= `BMC2_D0;
    tick(3);
    chk({pme_assert, local_reset_output_n}, 2'b01);
  endtask

  // D3hot to D0 with power reset on: count the reset pulse in a window
  task automatic s_psrst();
    int n;
    n = 0;
    wr(`BMC2_OFF_CTL2, 32'h0000_0002);
    @(posedge core_clk);
    pm_state <= `BMC2_D3HOT;
    repeat (3) @(posedge core_clk);
    pm_state <= `BMC2_D0;
    for (int k = 0; k < 12; k++) begin
      tick(1);
      if ({internal_reset_req, local_reset_output_n} === 2'b10) n++;
    end
    chk(n, LRST);
    rd(`BMC2_OFF_STAT, 32'h0000_0004);
  endtask

  // main sequence; a second reset with the strap high closes the run
  initial begin
    {sys_rst, local_interrupt_line_n} = 2'b11;
    {reg_wr, reg_rd, pci_disable_strap, sda_pin, eeprom_present_strap, ee_load} = '0;
    {ee_pci_access_disable, master_abort_error_disable, pf_image, reg_req_pci} = '0;
    {reg_req_local, pme_enable, fire, dly, ta, ma, reg_addr, reg_wdata, par_gen_data} = '0;
    {wr_burst_req, first_prefetch_count, pm_state, par_check} = '0;
    s_reset(1'b0);
    s_regs();
    s_abort();
    s_irq();
    s_shape();
    s_par();
    s_park();
    s_ee();
    s_pme(1'b0);
    s_pme(1'b1);
    rd(`BMC2_OFF_STAT, 32'h0000_0008);
    wr(`BMC2_OFF_STAT, 32'h0000_000f);
    s_psrst();
    s_reset(1'b1);
    stop_test();
  end
endmodule

bind bmc2_regs bmc2_regs_checker #(.LRST_CYC(LRST_CYC)) chk_u (.*);
